// file: rtl/esr_top.sv
// Event snapshot recorder: live counters, host time value and frozen event record.
`timescale 1ns/1ns
`default_nettype none
`include "esr_cfg.svh"
module esr_top #(
  parameter longint unsigned MINUTE_CYCLES = `ESR_MINUTE_CYCLES
) (
  input  wire logic                    sys_clk,
  input  wire logic                    nrst,
  input  wire logic                    power_on_request_n,
  input  wire logic                    mains_present,
  input  wire logic                    shutdown_fault,
  input  wire esr_pkg::esr_status_type status_in,
  input  wire logic                    cmd_valid,
  input  wire logic [7:0]              cmd_code,
  input  wire logic                    cmd_write,
  input  wire logic [31:0]             cmd_wdata,
  output var  logic [31:0]             cmd_rdata,
  output var  logic                    cmd_ack,
  output var  esr_pkg::esr_live_type   live_out,
  output var  esr_pkg::esr_record_type record_out,
  output var  logic                    record_valid,
  output var  logic                    record_pulse
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************

  logic req_n_s;
  logic mains_s;
  logic fault_s;

  // Pins from outside the clock domain each pass three synchroniser stages and an output flip-flop.
  esr_sync #(.RST_VAL(1'b1)) u_sync_req (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .async_in (power_on_request_n),
    .sync_out (req_n_s)
  );

  esr_sync #(.RST_VAL(1'b0)) u_sync_mains (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .async_in (mains_present),
    .sync_out (mains_s)
  );

  esr_sync #(.RST_VAL(1'b0)) u_sync_fault (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .async_in (shutdown_fault),
    .sync_out (fault_s)
  );

  // ****************************************************************
  // Edge detection
  // ****************************************************************

  logic req_n_d_r;
  logic mains_d_r;
  logic fault_d_r;
  logic req_on_edge;
  logic mains_on_edge;
  logic fault_edge;

  // Delayed copies of the synchronised levels.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      req_n_d_r <= 1'b1;
      mains_d_r <= 1'b0;
      fault_d_r <= 1'b0;
    end else begin
      req_n_d_r <= req_n_s;
      mains_d_r <= mains_s;
      fault_d_r <= fault_s;
    end
  end

  // A request reasserting after release ends one off-then-on cycle.
  assign req_on_edge   = req_n_d_r & ~req_n_s;
  // Mains returning ends one mains-loss cycle.
  assign mains_on_edge = ~mains_d_r & mains_s;
  // A rising fault level is one recordable event.
  assign fault_edge    = ~fault_d_r & fault_s;

  // ****************************************************************
  // Cycle qualification
  // ****************************************************************

  logic req_off_seen_r;
  logic mains_off_seen_r;

  // A request off phase counts only if mains stayed present through it.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      req_off_seen_r <= 1'b0;
    end else if (!mains_s) begin
      req_off_seen_r <= 1'b0;
    end else if (!req_n_d_r && req_n_s) begin
      req_off_seen_r <= 1'b1;
    end else if (req_on_edge) begin
      req_off_seen_r <= 1'b0;
    end
  end

  // A mains-loss phase counts only if the request stayed asserted through it.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mains_off_seen_r <= 1'b0;
    end else if (req_n_s) begin
      mains_off_seen_r <= 1'b0;
    end else if (mains_d_r && !mains_s) begin
      mains_off_seen_r <= 1'b1;
    end else if (mains_on_edge) begin
      mains_off_seen_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Live counters
  // ****************************************************************

  logic [`ESR_CYCLE_W-1:0]  req_cycles_r;
  logic [`ESR_CYCLE_W-1:0]  mains_cycles_r;
  logic [`ESR_ONTIME_W-1:0] on_time_r;
  logic [32:0]              minute_cnt_r; // A full minute needs more than 32 bits.
  logic                     minute_tick;

  // Request cycle counter, held at its maximum once reached.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      req_cycles_r <= 16'h0000;
    end else if (req_on_edge && req_off_seen_r && mains_s) begin
      if (req_cycles_r != `ESR_CYCLE_MAX) begin
        req_cycles_r <= req_cycles_r + 16'h0001;
      end
    end
  end

  // Mains-loss cycle counter, also saturating.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mains_cycles_r <= 16'h0000;
    end else if (mains_on_edge && mains_off_seen_r && !req_n_s) begin
      if (mains_cycles_r != `ESR_CYCLE_MAX) begin
        mains_cycles_r <= mains_cycles_r + 16'h0001;
      end
    end
  end

  // Minute divider runs while the supply is on, giving a one-cycle tick.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      minute_cnt_r <= 33'h0_0000_0000;
    end else if (!req_n_s && mains_s) begin
      if (minute_cnt_r == 33'(MINUTE_CYCLES - 64'd1)) begin
        minute_cnt_r <= 33'h0_0000_0000;
      end else begin
        minute_cnt_r <= minute_cnt_r + 33'h0_0000_0001;
      end
    end
  end

  assign minute_tick = !req_n_s && mains_s && (minute_cnt_r == 33'(MINUTE_CYCLES - 64'd1));

  // On-time counter in whole minutes, held at its maximum.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      on_time_r <= 24'h00_0000;
    end else if (minute_tick && on_time_r != 24'hFF_FFFF) begin
      on_time_r <= on_time_r + 24'h00_0001;
    end
  end

  // ****************************************************************
  // Host time value
  // ****************************************************************

  logic [`ESR_TIME_W-1:0] time_r;
  logic                   cmd_hit;

  assign cmd_hit = cmd_valid && (cmd_code == `ESR_CMD_TIME_SET);

  // The time value is only stored, never advanced here; host keeps it fresh.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      time_r <= 32'h0000_0000;
    end else if (cmd_hit && cmd_write) begin
      time_r <= cmd_wdata;
    end
  end

  // Command answer: one-cycle acknowledge with the time value on reads.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_ack   <= 1'b0;
      cmd_rdata <= 32'h0000_0000;
    end else begin
      cmd_ack <= cmd_hit;
      if (cmd_hit && !cmd_write) begin
        cmd_rdata <= time_r;
      end
    end
  end

  // ****************************************************************
  // Event record
  // ****************************************************************

  // Status values are the filtered sensor results; short glitches never reach them.
  // Every field is frozen in the same cycle, overwriting the previous record.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      record_out   <= '0;
      record_valid <= 1'b0;
      record_pulse <= 1'b0;
    end else begin
      record_pulse <= fault_edge;
      if (fault_edge) begin
        record_out.on_time_min    <= on_time_r;
        record_out.time_stamp     <= time_r;
        record_out.mains_cycles   <= mains_cycles_r;
        record_out.request_cycles <= req_cycles_r;
        record_out.status         <= status_in;
        record_valid              <= 1'b1;
      end
    end
  end

  // Live counter view for the management logic.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      live_out <= '0;
    end else begin
      live_out.on_time_min    <= on_time_r;
      live_out.mains_cycles   <= mains_cycles_r;
      live_out.request_cycles <= req_cycles_r;
    end
  end

endmodule
`default_nettype wire

// file: rtl/esr_cfg.svh
// Constants of the event snapshot recorder: timing counts, record layout, counter saturation value and command code.
// ****************************************************************
// What this block does
// - Count request off-on cycles while mains present.
// - Request cycle counter saturates at FFFFh.
// - Hold 38-byte record of latest event; this block holds only its 16-byte frozen part.
// - Copy live counters into record on event.
// - Three-byte on-time field, one minute per count.
// - Four-byte time stamp holds last host write.
// - Snapshot mains-loss cycle count, counted while requested.
// - Snapshot request cycle count, counted while mains present.
// - Record status word, iout, input, temperature bytes.
// - Status comes from filtered values, brief faults missed.
// - Shutdown fault saves all live data as record.
// - Time-set command reads and writes four bytes.
// ****************************************************************
`ifndef ESR_CFG_SVH
`define ESR_CFG_SVH

// Clock period in ns and time unit lengths.
`define ESR_CLK_NS         10
`define ESR_MINUTE_NS      64'd60_000_000_000
`define ESR_MINUTE_CYCLES  (`ESR_MINUTE_NS / `ESR_CLK_NS)
// Record size in bytes.
`define ESR_RECORD_BYTES   38
// Field widths in bits.
`define ESR_ONTIME_W       24
`define ESR_CYCLE_W        16
`define ESR_TIME_W         32
// Saturation value of the cycle counters.
`define ESR_CYCLE_MAX      16'hFFFF
// Time-set command code.
`define ESR_CMD_TIME_SET   8'hDD

`endif

// file: rtl/esr_pkg.sv
// Types of the event snapshot recorder.
package esr_pkg;

  // Management bus status values as sampled from the filtered sensors.
  typedef struct packed {
    logic [15:0] status_word;
    logic [7:0]  status_iout;
    logic [7:0]  status_input;
    logic [7:0]  status_temperature;
  } esr_status_type;

  // Frozen part of the event record held by this block.
  typedef struct packed {
    logic [23:0]    on_time_min;
    logic [31:0]    time_stamp;
    logic [15:0]    mains_cycles;
    logic [15:0]    request_cycles;
    esr_status_type status;
  } esr_record_type;

  // Live counter set.
  typedef struct packed {
    logic [23:0] on_time_min;
    logic [15:0] mains_cycles;
    logic [15:0] request_cycles;
  } esr_live_type;

endpackage

// file: rtl/esr_sync.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module esr_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic async_in,
  output var  logic sync_out
);

  logic [2:0] stage_r;

  // Shift the pin through three flip-flops.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stage_r <= {3{RST_VAL}};
    end else begin
      stage_r <= {stage_r[1:0], async_in};
    end
  end

  // Take a new level only when the two later stages agree.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync_out <= RST_VAL;
    end else if (stage_r[1] == stage_r[2]) begin
      sync_out <= stage_r[2];
    end
  end

endmodule
`default_nettype wire

// file: verification/esr_chk.sv
// Port-level checks of the event snapshot recorder.
`timescale 1ns/1ns
`default_nettype none
module esr_chk (
  input wire logic                    sys_clk,
  input wire logic                    nrst,
  input wire logic                    shutdown_fault,
  input wire logic                    cmd_valid,
  input wire logic [7:0]              cmd_code,
  input wire logic                    cmd_write,
  input wire logic [31:0]             cmd_wdata,
  input wire logic [31:0]             cmd_rdata,
  input wire logic                    cmd_ack,
  input wire esr_pkg::esr_live_type   live_out,
  input wire esr_pkg::esr_record_type record_out,
  input wire logic                    record_valid,
  input wire logic                    record_pulse
);
  logic [31:0] time_r;
  // Shadows the last time value that the host wrote.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      time_r <= 32'h0000_0000;
    end else if (cmd_valid && cmd_code == 8'hDD && cmd_write) begin
      time_r <= cmd_wdata;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_dd_req;
    cmd_valid && cmd_code == 8'hDD;
  endsequence
  sequence s_fault_rise;
    $rose(shutdown_fault);
  endsequence
  a_ack_follows: assert property (s_dd_req |=> cmd_ack)
    else $error("no ack");
  a_ack_refused: assert property (!(cmd_valid && cmd_code == 8'hDD) |=> !cmd_ack)
    else $error("stray ack");
  a_read_value: assert property (s_dd_req ##0 !cmd_write |=> cmd_rdata == time_r)
    else $error("read value");
  a_fault_records: assert property (s_fault_rise |-> ##[3:8] record_pulse)
    else $error("no record");
  a_record_hold: assert property (!record_pulse |-> $stable(record_out))
    else $error("record moved");
  a_valid_sticky: assert property (record_pulse || $past(record_valid) |-> record_valid)
    else $error("valid lost");
  a_stamp_match: assert property (record_pulse |-> record_out.time_stamp == time_r)
    else $error("stamp");
  a_req_saturate: assert property ($past(live_out.request_cycles) == 16'hFFFF
    |-> live_out.request_cycles == 16'hFFFF) else $error("wrapped");
  a_req_step: assert property ($changed(live_out.request_cycles)
    |-> live_out.request_cycles == $past(live_out.request_cycles) + 16'h0001)
    else $error("step");
  a_snap_counts: assert property (record_pulse |->
    record_out.on_time_min == live_out.on_time_min
    && record_out.mains_cycles == live_out.mains_cycles
    && record_out.request_cycles == live_out.request_cycles) else $error("snapshot");
endmodule
bind esr_top esr_chk esr_chk_inst (
  .sys_clk(sys_clk), .nrst(nrst), .shutdown_fault(shutdown_fault),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_write(cmd_write),
  .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack),
  .live_out(live_out), .record_out(record_out),
  .record_valid(record_valid), .record_pulse(record_pulse)
);
`default_nettype wire

// file: verification/esr_host.sv
// Host controller model that sends time-set commands.
`timescale 1ns/1ns
`default_nettype none
module esr_host (
  input  wire logic        sys_clk,
  input  wire logic        cmd_ack,
  input  wire logic [31:0] cmd_rdata,
  output var  logic        cmd_valid,
  output var  logic [7:0]  cmd_code,
  output var  logic        cmd_write,
  output var  logic [31:0] cmd_wdata
);
  // Idle command port at time zero.
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    cmd_write = 1'b0;
    cmd_wdata = 32'h0000_0000;
  end
  // Sends one strobe of seconds since 1970 and takes the answer a cycle later.
  task automatic xfer(input logic [7:0] c, input logic w, input logic [31:0] t,
                      output logic a, output logic [31:0] q);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_write <= w;
    cmd_wdata <= t;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    cmd_wdata <= ~t; // Released data must not look valid.
    #1;
    a = cmd_ack;
    q = cmd_rdata;
  endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
// Self-checking testbench of the event snapshot recorder.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic sys_clk, nrst, req_n, mains, fault, ack, valid, pulse;
  logic [7:0] code, n;
  logic write;
  logic got_ack;
  logic [31:0] wdata, rdata, q;
  logic [15:0] exp_req, exp_mains;
  logic [23:0] t0;
  esr_pkg::esr_status_type status;
  esr_pkg::esr_live_type live;
  esr_pkg::esr_record_type rec;
  int err_total, comparisons, i;
  esr_top #(.MINUTE_CYCLES(10)) esr_top_inst (
    .sys_clk(sys_clk), .nrst(nrst), .power_on_request_n(req_n),
    .mains_present(mains), .shutdown_fault(fault), .status_in(status),
    .cmd_valid(valid), .cmd_code(code), .cmd_write(write), .cmd_wdata(wdata),
    .cmd_rdata(rdata), .cmd_ack(ack), .live_out(live), .record_out(rec),
    .record_valid(), .record_pulse(pulse));
  esr_host esr_host_inst (
    .sys_clk(sys_clk), .cmd_ack(ack), .cmd_rdata(rdata), .cmd_valid(valid),
    .cmd_code(code), .cmd_write(write), .cmd_wdata(wdata));
  // Compares one value and counts the result.
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Sets both pins and lets them pass the synchronisers.
  task automatic pins(input logic r, input logic m);
    @(posedge sys_clk);
    req_n <= r;
    mains <= m;
    repeat (8) @(posedge sys_clk);
    #1;
  endtask
  // Time-set writes, reads and a refused code.
  task automatic t_time;
    esr_host_inst.xfer(8'hDD, 1'b1, 32'h6500_0001, got_ack, q);
    check(got_ack, 1'b1);
    esr_host_inst.xfer(8'hDD, 1'b0, 32'h0000_0000, got_ack, q);
    check(q, 32'h6500_0001);
    esr_host_inst.xfer(8'hDC, 1'b1, 32'hFFFF_0000, got_ack, q);
    check(got_ack, 1'b0);
    esr_host_inst.xfer(8'hDD, 1'b0, 32'h0000_0000, got_ack, q);
    check(q, 32'h6500_0001);
    $display("t_time done");
  endtask
  // Request and mains cycle counting under each condition.
  task automatic t_cycles;
    pins(1'b0, 1'b1);
    exp_req = live.request_cycles;
    exp_mains = live.mains_cycles;
    for (i = 0; i < 3; i++) begin
      pins(1'b1, 1'b1);
      pins(1'b0, 1'b1);
      exp_req++;
      check(live.request_cycles, exp_req);
    end
    pins(1'b0, 1'b0);
    pins(1'b0, 1'b1);
    check(live.mains_cycles, exp_mains + 16'h0001);
    exp_mains++;
    pins(1'b1, 1'b1);
    pins(1'b1, 1'b0);
    pins(1'b1, 1'b1);
    pins(1'b0, 1'b1);
    check(live.request_cycles, exp_req);
    check(live.mains_cycles, exp_mains);
    t0 = live.on_time_min;
    repeat (50) @(posedge sys_clk);
    #1;
    check(live.on_time_min, t0 + 24'h00_0005);
    $display("t_cycles done");
  endtask
  // One shutdown event, its frozen record and no repeat while held.
  task automatic t_event(input esr_pkg::esr_status_type s, input logic [31:0] t);
    esr_host_inst.xfer(8'hDD, 1'b1, t, got_ack, q);
    @(posedge sys_clk);
    status <= s;
    repeat (4) @(posedge sys_clk);
    fault <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      #1;
      if (pulse === 1'b1) break;
    end
    if (pulse !== 1'b1) begin
      err_total++;
      end_of_test();
    end
    check(rec.time_stamp, t);
    check(rec.request_cycles, exp_req);
    check(rec.mains_cycles, exp_mains);
    check(rec.status, s);
    check(esr_top_inst.record_valid, 1'b1);
    n = 8'h00;
    for (i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      #1;
      n = n + {7'h00, pulse};
    end
    check(n, 8'h00);
    fault <= 1'b0;
    repeat (8) @(posedge sys_clk);
    $display("t_event done");
  endtask
  // Clock of 100 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Main sequence.
  initial begin
    nrst = 1'b0;
    req_n = 1'b1;
    mains = 1'b0;
    fault = 1'b0;
    status = 40'h00_0000_0000;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    #1;
    check(esr_top_inst.record_valid, 1'b0);
    check(ack, 1'b0);
    t_time();
    t_cycles();
    t_event(40'h08_4021_1080, 32'h6500_0A00);
    t_event(40'h40_0280_0420, 32'h6500_0B3C);
    end_of_test();
  end
endmodule
`default_nettype wire
